// ==== mnm_notice_monitor.sv ====
// Notice monitor: threshold checks, notice outputs, indicator blink, history, APB
// Operation
// - Active notice raises its own bit output
// - Bit output routes to terminal or remote
// - Combined output when any acting notice present
// - Indicator blinks orange twice while acting
// - Notices never stop or alter motor operation
// - Non-acting notice drives only its bit
// - Auto-clear on: notice follows release condition
// - Auto-clear off: notice latched after release
// - History keeps 16 entries, newest first
// - Entry holds code, time and contents
// - Host reads and clears history over link
// - Clear refused while operator lock off
// - Temperature bit 2, release 5 C below
// - Overvoltage bit 4, release 0.5 V below
// - Undervoltage bit 5, release 0.5 V above
// - Load bit 7, release below threshold
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "mnm_consts.svh"

module mnm_notice_monitor #(
  parameter int MS_CYCLES = `MNM_MS_NS / `MNM_CLK_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire mnm_pkg::mnm_apb_req_t apbReq,
  output var mnm_pkg::mnm_apb_rsp_t apbRsp,
  input wire mnm_pkg::mnm_meas_t meas,
  input wire logic operatorLockInput,
  output var logic [7:0] noticeDirect,
  output var logic anyNoticeOutput,
  output var logic powerAlarmIndicator,
  output var logic irq
);
  import mnm_pkg::*;

  mnm_state_t r;
  mnm_state_t n;
  logic wr;
  logic [7:0] setCond;
  logic [7:0] relCond;
  logic [7:0] clrNotice;
  logic [2:0] clrIrq;
  logic [2:0] setIrq;
  logic histClr;
  logic push;
  logic [7:0] pushCode;
  logic [15:0] pushData;
  logic msTick;
  mnm_entry_t selEntry;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    n = r;
    wr = apbReq.psel & apbReq.penable & apbReq.pwrite & r.rsp.pready;
    clrNotice = 8'h00;
    clrIrq = 3'h0;
    setIrq = 3'h0;
    histClr = 1'b0;
    push = 1'b0;
    pushCode = 8'h00;
    pushData = 16'h0000;
    selEntry = (r.sel < r.count[3:0] || r.count == `MNM_HIST_DEPTH) ? r.hist[r.sel] : '0;

    // Lock pin is asynchronous to clk
    n.lockMeta = operatorLockInput;
    n.lockSync = r.lockMeta;

    // One wait state, so read data and pready both leave flops
    n.rsp.pready = apbReq.psel & apbReq.penable & ~r.rsp.pready;
    n.rsp.pslverr = 1'b0;
    n.rsp.prdata = 32'h0000_0000;
    if (n.rsp.pready)
    begin
      case (apbReq.paddr)
        `MNM_OFS_CTRL: n.rsp.prdata = {31'h0, r.autoClear};
        `MNM_OFS_ACTION: n.rsp.prdata = {24'h0, r.action};
        `MNM_OFS_ROUTE: n.rsp.prdata = {24'h0, r.route};
        `MNM_OFS_NOTICE: n.rsp.prdata = {24'h0, r.notice};
        `MNM_OFS_REMOTE: n.rsp.prdata = {24'h0, r.remote};
        `MNM_OFS_TH_TEMP: n.rsp.prdata = {16'h0, r.thTemp};
        `MNM_OFS_TH_OVER: n.rsp.prdata = {16'h0, r.thOver};
        `MNM_OFS_TH_UNDER: n.rsp.prdata = {16'h0, r.thUnder};
        `MNM_OFS_TH_LOAD: n.rsp.prdata = {16'h0, r.thLoad};
        `MNM_OFS_HIST_CMD: n.rsp.prdata = {27'h0, r.count};
        `MNM_OFS_HIST_SEL: n.rsp.prdata = {28'h0, r.sel};
        `MNM_OFS_HIST_CODE: n.rsp.prdata = {24'h0, selEntry.code};
        `MNM_OFS_HIST_TIME: n.rsp.prdata = selEntry.stamp;
        `MNM_OFS_HIST_DATA: n.rsp.prdata = {16'h0, selEntry.data};
        `MNM_OFS_IRQ_STAT: n.rsp.prdata = {29'h0, r.irqStat};
        `MNM_OFS_IRQ_MASK: n.rsp.prdata = {29'h0, r.irqMask};
        `MNM_OFS_TIME: n.rsp.prdata = r.timeMs;
        default: n.rsp.pslverr = 1'b1;
      endcase
    end

    if (wr)
    begin
      case (apbReq.paddr)
        `MNM_OFS_CTRL: n.autoClear = apbReq.pwdata[0];
        `MNM_OFS_ACTION: n.action = apbReq.pwdata[7:0] & `MNM_NOTICE_MASK;
        `MNM_OFS_ROUTE: n.route = apbReq.pwdata[7:0] & `MNM_NOTICE_MASK;
        `MNM_OFS_NOTICE: clrNotice = apbReq.pwdata[7:0];
        `MNM_OFS_TH_TEMP: n.thTemp = apbReq.pwdata[15:0];
        `MNM_OFS_TH_OVER: n.thOver = apbReq.pwdata[15:0];
        `MNM_OFS_TH_UNDER: n.thUnder = apbReq.pwdata[15:0];
        `MNM_OFS_TH_LOAD: n.thLoad = apbReq.pwdata[15:0];
        `MNM_OFS_HIST_CMD: histClr = apbReq.pwdata[0];
        `MNM_OFS_HIST_SEL: n.sel = apbReq.pwdata[3:0];
        `MNM_OFS_IRQ_STAT: clrIrq = apbReq.pwdata[2:0];
        `MNM_OFS_IRQ_MASK: n.irqMask = apbReq.pwdata[2:0];
        default: ;
      endcase
    end

    // Threshold checks; 17-bit sums keep the hysteresis free of wrap
    setCond = 8'h00;
    relCond = 8'h00;
    setCond[`MNM_BIT_TEMP] = meas.temp >= r.thTemp;
    relCond[`MNM_BIT_TEMP] = ({1'b0, meas.temp} + `MNM_HYST_TEMP) <= {1'b0, r.thTemp};
    setCond[`MNM_BIT_OVER] = meas.volt >= r.thOver;
    relCond[`MNM_BIT_OVER] = ({1'b0, meas.volt} + `MNM_HYST_VOLT) <= {1'b0, r.thOver};
    setCond[`MNM_BIT_UNDER] = meas.volt <= r.thUnder;
    relCond[`MNM_BIT_UNDER] = {1'b0, meas.volt} >= ({1'b0, r.thUnder} + `MNM_HYST_VOLT);
    setCond[`MNM_BIT_LOAD] = meas.torque >= r.thLoad;
    relCond[`MNM_BIT_LOAD] = meas.torque < r.thLoad;
    n.cond = setCond | (r.cond & ~relCond);

    // Latched notice cleared by a one; a live condition wins over the clear
    if (n.autoClear)
      n.notice = n.cond;
    else
      n.notice = n.cond | (r.notice & ~clrNotice);

    // Outputs only report; nothing here feeds drive enable or speed
    n.noticeDirect = n.notice & ~n.route;
    n.remote = n.notice & n.route;
    n.anyNotice = |(n.notice & n.action);

    // Millisecond time base for stamps and the blink pattern
    msTick = r.msCnt == 17'(MS_CYCLES - 1);
    n.msCnt = msTick ? 17'h00000 : r.msCnt + 17'h00001;
    if (msTick)
      n.timeMs = r.timeMs + 32'h0000_0001;

    // Pattern restarts on every new acting episode, so the first blink is at once
    if (!n.anyNotice)
    begin
      n.slotMs = 8'h00;
      n.slot = 4'h0;
    end
    else if (msTick)
    begin
      n.slotMs = (r.slotMs == `MNM_BLINK_SLOT_MS - 8'h01) ? 8'h00 : r.slotMs + 8'h01;
      if (r.slotMs == `MNM_BLINK_SLOT_MS - 8'h01)
        n.slot = (r.slot == `MNM_BLINK_SLOTS - 4'h1) ? 4'h0 : r.slot + 4'h1;
    end
    n.indicator = n.anyNotice & (n.slot == `MNM_BLINK_ON_A || n.slot == `MNM_BLINK_ON_B);

    // Simultaneous rises queue up and are logged one per cycle, low bit first
    n.pend = r.pend | (n.cond & ~r.cond);
    for (int i = 0; i < 8; i++)
    begin
      if (r.pend[i] && !push)
      begin
        push = 1'b1;
        pushCode = 8'(i);
        n.pend[i] = 1'b0;
      end
    end
    case (pushCode)
      8'h02: pushData = meas.temp;
      8'h04: pushData = meas.volt;
      8'h05: pushData = meas.volt;
      default: pushData = meas.torque;
    endcase

    if (histClr && r.lockSync)
      n.count = 5'h00;
    if (histClr && !r.lockSync)
      setIrq[`MNM_IRQ_REFUSED] = 1'b1;
    if (push)
    begin
      for (int i = 15; i > 0; i--)
        n.hist[i] = r.hist[i - 1];
      n.hist[0] = '{code: pushCode, stamp: r.timeMs, data: pushData};
      setIrq[`MNM_IRQ_NOTICE] = 1'b1;
      if (n.count == `MNM_HIST_DEPTH)
        setIrq[`MNM_IRQ_DROPPED] = 1'b1;
      else
        n.count = n.count + 5'h01;
    end

    n.irqStat = setIrq | (r.irqStat & ~clrIrq);
    n.irq = |(n.irqStat & n.irqMask);
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.autoClear <= 1'b1;
      r.action <= `MNM_RST_ACTION;
      r.route <= `MNM_RST_ROUTE;
      r.thTemp <= `MNM_RST_TH_TEMP;
      r.thOver <= `MNM_RST_TH_OVER;
      r.thUnder <= `MNM_RST_TH_UNDER;
      r.thLoad <= `MNM_RST_TH_LOAD;
    end
    else
      r <= n;
  end

  assign apbRsp = r.rsp;
  assign noticeDirect = r.noticeDirect;
  assign anyNoticeOutput = r.anyNotice;
  assign powerAlarmIndicator = r.indicator;
  assign irq = r.irq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  bit_routing_a: assert property (
    r.noticeDirect == (r.notice & ~r.route) && r.remote == (r.notice & r.route))
    else $error("notice bit outputs do not match notices and routing");
  combined_out_a: assert property (
    r.anyNotice == |(r.notice & r.action))
    else $error("combined notice output wrong for acting set");
  blink_gate_a: assert property (
    (!r.anyNotice |-> !r.indicator) and ($rose(r.anyNotice) |-> r.indicator))
    else $error("indicator not tied to acting notices");
  auto_clear_a: assert property (
    r.autoClear |-> r.notice == r.cond)
    else $error("auto clear notice does not follow condition");
  latch_hold_a: assert property (
    (!r.autoClear && !wr) |=> (r.notice & $past(r.notice)) == $past(r.notice))
    else $error("latched notice dropped without clear");
  hist_depth_a: assert property (
    (r.count <= `MNM_HIST_DEPTH)
    and (push && !histClr && r.count == `MNM_HIST_DEPTH |=> r.count == 5'h10))
    else $error("history depth exceeded or lost");
  hist_push_a: assert property (
    push |=> r.hist[0].code == $past(pushCode) && r.hist[0].stamp == $past(r.timeMs)
      && r.hist[1] == $past(r.hist[0]))
    else $error("history push wrong");
  hist_clear_a: assert property (
    histClr && r.lockSync |=> r.count <= 5'h01)
    else $error("history clear not done");
  clear_refuse_a: assert property (
    histClr && !r.lockSync |=> r.count >= $past(r.count) && r.irqStat[`MNM_IRQ_REFUSED])
    else $error("history cleared while lock off");
  temp_notice_a: assert property (
    (meas.temp >= r.thTemp |=> r.cond[2])
    and (r.cond[2] && ({1'b0, meas.temp} + 17'h00005) > {1'b0, r.thTemp} |=> r.cond[2]))
    else $error("temperature notice hysteresis wrong");
  over_notice_a: assert property (
    meas.volt >= r.thOver |=> r.cond[4])
    else $error("overvoltage notice not set");
  under_notice_a: assert property (
    meas.volt <= r.thUnder |=> r.cond[5])
    else $error("undervoltage notice not set");
  load_notice_a: assert property (
    (meas.torque >= r.thLoad |=> r.cond[7]) and (meas.torque < r.thLoad |=> !r.cond[7]))
    else $error("load notice wrong");

  // ****************************************
  // Release, response and flag checks
  // ****************************************
  // Release checks use the same 17-bit sums so a threshold near the top cannot wrap
  temp_release_a: assert property (
    ({1'b0, meas.temp} + 17'h00005) <= {1'b0, r.thTemp} |=> !r.cond[2])
    else $error("temperature notice not released");
  over_release_a: assert property (
    ({1'b0, meas.volt} + 17'h00005) <= {1'b0, r.thOver} |=> !r.cond[4])
    else $error("overvoltage notice not released");
  over_hold_a: assert property (
    r.cond[4] && ({1'b0, meas.volt} + 17'h00005) > {1'b0, r.thOver} |=> r.cond[4])
    else $error("overvoltage notice released early");
  under_release_a: assert property (
    {1'b0, meas.volt} >= ({1'b0, r.thUnder} + 17'h00005) |=> !r.cond[5])
    else $error("undervoltage notice not released");
  under_hold_a: assert property (
    r.cond[5] && {1'b0, meas.volt} < ({1'b0, r.thUnder} + 17'h00005) |=> r.cond[5])
    else $error("undervoltage notice released early");
  notice_bits_a: assert property (
    (r.notice & ~`MNM_NOTICE_MASK) == 8'h00)
    else $error("notice set outside the notice bits");
  lit_slots_a: assert property (
    r.indicator |-> (r.slot == `MNM_BLINK_ON_A || r.slot == `MNM_BLINK_ON_B))
    else $error("indicator lit outside blink slots");
  slot_idle_a: assert property (
    !r.anyNotice |-> r.slot == 4'h0)
    else $error("blink pattern not restarted");
  ctrl_write_a: assert property (
    wr && apbReq.paddr == `MNM_OFS_CTRL |=> r.autoClear == $past(apbReq.pwdata[0]))
    else $error("auto clear setting not written");
  latch_w1c_a: assert property (
    !r.autoClear && wr && apbReq.paddr == `MNM_OFS_NOTICE
    |=> r.notice == (r.cond | ($past(r.notice) & ~$past(apbReq.pwdata[7:0]))))
    else $error("latched notice clear wrong");
  count_step_a: assert property (
    push && !histClr && r.count < `MNM_HIST_DEPTH |=> r.count == $past(r.count) + 5'h01)
    else $error("history count not advanced");
  dropped_flag_a: assert property (
    push && !histClr && r.count == `MNM_HIST_DEPTH |=> r.irqStat[`MNM_IRQ_DROPPED])
    else $error("dropped entry not flagged");
  notice_flag_a: assert property (
    push |=> r.irqStat[`MNM_IRQ_NOTICE])
    else $error("logged notice not flagged");
  irq_level_a: assert property (
    r.irq == |(r.irqStat & r.irqMask))
    else $error("interrupt level wrong");
  lock_sync_a: assert property (
    r.lockSync == $past(r.lockMeta))
    else $error("lock synchroniser skipped a stage");
  ready_answer_a: assert property (
    apbReq.psel && apbReq.penable && !r.rsp.pready |=> r.rsp.pready)
    else $error("bus access not answered after one wait state");
  ready_pulse_a: assert property (
    r.rsp.pready |=> !r.rsp.pready)
    else $error("ready held longer than one cycle");
  err_with_ready_a: assert property (
    r.rsp.pslverr |-> r.rsp.pready)
    else $error("error response without ready");
  idle_data_a: assert property (
    !r.rsp.pready |-> r.rsp.prdata == 32'h0000_0000)
    else $error("read data not zero outside the answer");

  cover property (push ##1 r.indicator);
  cover property (push && r.count == `MNM_HIST_DEPTH);
  cover property (histClr && !r.lockSync);
  cover property (!r.autoClear && r.notice != 8'h00 && r.cond == 8'h00);
  cover property (r.rsp.pready && r.rsp.pslverr);

endmodule
`default_nettype wire

// ==== mnm_consts.svh ====
// Constants of the maintenance notice monitor: offsets, fields, resets, timing
`ifndef MNM_CONSTS_SVH
`define MNM_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define MNM_OFS_CTRL 8'h00
`define MNM_OFS_ACTION 8'h04
`define MNM_OFS_ROUTE 8'h08
`define MNM_OFS_NOTICE 8'h0C
`define MNM_OFS_REMOTE 8'h10
`define MNM_OFS_TH_TEMP 8'h14
`define MNM_OFS_TH_OVER 8'h18
`define MNM_OFS_TH_UNDER 8'h1C
`define MNM_OFS_TH_LOAD 8'h20
`define MNM_OFS_HIST_CMD 8'h24
`define MNM_OFS_HIST_SEL 8'h28
`define MNM_OFS_HIST_CODE 8'h2C
`define MNM_OFS_HIST_TIME 8'h30
`define MNM_OFS_HIST_DATA 8'h34
`define MNM_OFS_IRQ_STAT 8'h38
`define MNM_OFS_IRQ_MASK 8'h3C
`define MNM_OFS_TIME 8'h40

// ****************************************
// Notice bit positions and fields
// ****************************************
`define MNM_BIT_TEMP 2
`define MNM_BIT_OVER 4
`define MNM_BIT_UNDER 5
`define MNM_BIT_LOAD 7
`define MNM_NOTICE_MASK 8'hB4
`define MNM_IRQ_NOTICE 0
`define MNM_IRQ_REFUSED 1
`define MNM_IRQ_DROPPED 2
`define MNM_HIST_DEPTH 5'h10

// ****************************************
// Reset values and hysteresis (1 C, 0.1 V per LSB)
// ****************************************
`define MNM_RST_ACTION 8'hB4
`define MNM_RST_ROUTE 8'h00
`define MNM_RST_TH_TEMP 16'h0055
`define MNM_RST_TH_OVER 16'h012C
`define MNM_RST_TH_UNDER 16'h00C8
`define MNM_RST_TH_LOAD 16'h00C8
`define MNM_HYST_TEMP 17'h00005
`define MNM_HYST_VOLT 17'h00005

// ****************************************
// Timing
// ****************************************
`define MNM_CLK_NS 8
`define MNM_MS_NS 1000000
`define MNM_BLINK_SLOT_MS 8'hC8
`define MNM_BLINK_SLOTS 4'hA
`define MNM_BLINK_ON_A 4'h0
`define MNM_BLINK_ON_B 4'h2

`endif

// ==== mnm_pkg.sv ====
// Types shared by the maintenance notice monitor
`default_nettype none
package mnm_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } mnm_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mnm_apb_rsp_t;

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] volt;
    logic [15:0] torque;
  } mnm_meas_t;

  typedef struct packed {
    logic [7:0] code;
    logic [31:0] stamp;
    logic [15:0] data;
  } mnm_entry_t;

  typedef struct packed {
    mnm_apb_rsp_t rsp;
    logic autoClear;
    logic [7:0] action;
    logic [7:0] route;
    logic [7:0] cond;
    logic [7:0] notice;
    logic [7:0] pend;
    logic [15:0] thTemp;
    logic [15:0] thOver;
    logic [15:0] thUnder;
    logic [15:0] thLoad;
    logic [3:0] sel;
    logic [4:0] count;
    mnm_entry_t [15:0] hist;
    logic [2:0] irqStat;
    logic [2:0] irqMask;
    logic irq;
    logic lockMeta;
    logic lockSync;
    logic [16:0] msCnt;
    logic [31:0] timeMs;
    logic [7:0] slotMs;
    logic [3:0] slot;
    logic [7:0] noticeDirect;
    logic [7:0] remote;
    logic anyNotice;
    logic indicator;
  } mnm_state_t;

endpackage
`default_nettype wire

// ==== mnm_host_model.sv ====
// Host model issuing APB register transfers to the notice monitor
`timescale 1ns/1ps
`default_nettype none

module mnm_host_model (
  input wire logic clk,
  input wire mnm_pkg::mnm_apb_rsp_t apbRsp,
  output var mnm_pkg::mnm_apb_req_t apbReq
);
  import mnm_pkg::*;

  // ****************************************
  // Transfer task
  // ****************************************
  initial apbReq = '0;

  // Released lines show inverted values so stale data cannot pass
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    // Only the bench timeout ends a wait for ready
    do
      @(posedge clk);
    while (apbRsp.pready !== 1'b1);
    rdata = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq <= '{psel: 1'b0, penable: 1'b0, pwrite: ~wr, paddr: ~addr, pwdata: ~wdata};
  endtask
endmodule

`default_nettype wire

// ==== tb.sv ====
// Self-checking testbench of the notice monitor
`timescale 1ns/1ps
`default_nettype none
`include "mnm_consts.svh"
`define CHK(nm, exp, got) begin testsRun++; if ((got) !== (exp)) begin errors++; \
  $display("Error %s: expected %0h seen %0h", nm, exp, got); end end

module tb;
  import mnm_pkg::*;
  localparam int MS = 4;
  localparam int SLOT = 200 * MS;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  mnm_apb_req_t apbReq;
  mnm_apb_rsp_t apbRsp;
  mnm_meas_t meas = '{temp: 16'h0020, volt: 16'h00FA, torque: 16'h0010};
  logic operatorLockInput = 1'b1;
  logic [7:0] noticeDirect;
  logic anyNoticeOutput;
  logic powerAlarmIndicator;
  logic irq;
  int errors = 0;
  int testsRun = 0;
  int cycles = 0;
  logic [15:0] setv [4] = '{16'h0055, 16'h012C, 16'h00C8, 16'h00C8};
  logic [15:0] holdv [4] = '{16'h0051, 16'h0128, 16'h00CC, 16'h00C8};
  logic [15:0] relv [4] = '{16'h0050, 16'h0127, 16'h00CD, 16'h00C7};
  logic [15:0] idlev [4] = '{16'h0020, 16'h00FA, 16'h00FA, 16'h0010};
  int bitn [4] = '{2, 4, 5, 7};

  always #4 clk = ~clk;

  mnm_notice_monitor #(.MS_CYCLES(MS)) mnm_notice_monitor_i (.clk(clk), .rst_n(rst_n),
    .apbReq(apbReq), .apbRsp(apbRsp), .meas(meas), .operatorLockInput(operatorLockInput),
    .noticeDirect(noticeDirect), .anyNoticeOutput(anyNoticeOutput),
    .powerAlarmIndicator(powerAlarmIndicator), .irq(irq));
  mnm_host_model mnm_host_model_i (.clk(clk), .apbRsp(apbRsp), .apbReq(apbReq));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    logic e;
    mnm_host_model_i.xfer(1'b0, a, 32'h0, d, e);
    `CHK(nm, exp, d)
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic e;
    mnm_host_model_i.xfer(1'b1, a, v, d, e);
  endtask

  // Four edges cover condition, notice and history push latency
  task automatic setm(input int i, input logic [15:0] v);
    @(posedge clk);
    if (i == 0) meas.temp <= v;
    else if (i == 3) meas.torque <= v;
    else meas.volt <= v;
    repeat (4) @(posedge clk);
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", testsRun, errors);
    if (errors == 0 && testsRun > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Ceiling well above the blink and overflow sequences
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      $display("Error timeout: expected finish seen hang");
      conclude();
    end
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    logic [31:0] d;
    logic e;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd(`MNM_OFS_CTRL, 32'h1, "ctrl");
    rd(`MNM_OFS_ACTION, 32'hB4, "action");
    rd(`MNM_OFS_TH_TEMP, 32'h55, "thTemp");
    rd(`MNM_OFS_TH_OVER, 32'h12C, "thOver");
    rd(`MNM_OFS_TH_UNDER, 32'hC8, "thUnder");
    rd(`MNM_OFS_TH_LOAD, 32'hC8, "thLoad");
    rd(`MNM_OFS_HIST_CMD, 32'h0, "count");
    rd(`MNM_OFS_HIST_TIME, 32'h0, "empty stamp");
    mnm_host_model_i.xfer(1'b0, 8'h7C, 32'h0, d, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, d)
    $display("Test reset done");
    for (int i = 0; i < 4; i++)
    begin
      setm(i, setv[i]);
      `CHK("bit set", 1'b1, noticeDirect[bitn[i]])
      `CHK("any", 1'b1, anyNoticeOutput)
      if (i == 0)
        for (int k = 0; k < 4; k++)
        begin
          `CHK("blink", (k % 2 == 0), powerAlarmIndicator)
          repeat (SLOT) @(posedge clk);
        end
      rd(`MNM_OFS_HIST_CODE, bitn[i], "hcode");
      rd(`MNM_OFS_HIST_DATA, setv[i], "hdata");
      setm(i, holdv[i]);
      `CHK("bit hold", 1'b1, noticeDirect[bitn[i]])
      setm(i, relv[i]);
      `CHK("bit rel", 1'b0, noticeDirect[bitn[i]])
      setm(i, idlev[i]);
    end
    rd(`MNM_OFS_HIST_CMD, 32'h4, "count");
    wr(`MNM_OFS_HIST_SEL, 32'h3);
    rd(`MNM_OFS_HIST_CODE, 32'h2, "oldest code");
    wr(`MNM_OFS_HIST_SEL, 32'h0);
    $display("Test thresholds done");
    wr(`MNM_OFS_ACTION, 32'h0);
    wr(`MNM_OFS_ROUTE, 32'h80);
    setm(3, 16'h00C8);
    `CHK("direct", 8'h00, noticeDirect)
    `CHK("any off", 1'b0, anyNoticeOutput)
    `CHK("led off", 1'b0, powerAlarmIndicator)
    rd(`MNM_OFS_REMOTE, 32'h80, "remote");
    setm(3, 16'h0010);
    wr(`MNM_OFS_ACTION, 32'hB4);
    wr(`MNM_OFS_ROUTE, 32'h0);
    wr(`MNM_OFS_CTRL, 32'h0);
    setm(0, 16'h0055);
    setm(0, 16'h0020);
    `CHK("latched", 1'b1, noticeDirect[2])
    rd(`MNM_OFS_NOTICE, 32'h04, "notice");
    wr(`MNM_OFS_NOTICE, 32'h04);
    repeat (2) @(posedge clk);
    `CHK("unlatched", 8'h00, noticeDirect)
    wr(`MNM_OFS_CTRL, 32'h1);
    $display("Test action route latch done");
    rd(`MNM_OFS_IRQ_STAT, 32'h1, "irq stat");
    wr(`MNM_OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    `CHK("irq on", 1'b1, irq)
    wr(`MNM_OFS_IRQ_STAT, 32'h7);
    repeat (2) @(posedge clk);
    `CHK("irq off", 1'b0, irq)
    @(posedge clk);
    operatorLockInput <= 1'b0;
    repeat (4) @(posedge clk);
    wr(`MNM_OFS_HIST_CMD, 32'h1);
    rd(`MNM_OFS_HIST_CMD, 32'h6, "count kept");
    rd(`MNM_OFS_IRQ_STAT, 32'h2, "refused");
    operatorLockInput <= 1'b1;
    repeat (4) @(posedge clk);
    wr(`MNM_OFS_HIST_CMD, 32'h1);
    rd(`MNM_OFS_HIST_CMD, 32'h0, "cleared");
    wr(`MNM_OFS_IRQ_STAT, 32'h7);
    $display("Test irq clear done");
    for (int n = 0; n < 17; n++)
    begin
      setm(3, 16'h00C8);
      setm(3, 16'h0010);
    end
    rd(`MNM_OFS_HIST_CMD, 32'h10, "full count");
    rd(`MNM_OFS_IRQ_STAT, 32'h5, "dropped");
    wr(`MNM_OFS_HIST_SEL, 32'hF);
    rd(`MNM_OFS_HIST_CODE, 32'h7, "last code");
    $display("Test overflow done");
    conclude();
  end
endmodule

`default_nettype wire
